// *** cias_pkg.sv ***
// constants and types shared by the contact input action selector
// assumes a single 200 MHz clock; all slow rates are derived from it
package cias_pkg;

    // clock and timing
    localparam int unsigned CLOCK_HZ = 200_000_000;
    localparam int unsigned DEBOUNCE_US = 10_000;
    localparam int unsigned DEBOUNCE_CYCLES = (CLOCK_HZ / 1_000_000) * DEBOUNCE_US;
    localparam int unsigned BLINK_HALF_MS = 250;
    localparam int unsigned BLINK_HALF_CYCLES = (CLOCK_HZ / 1_000) * BLINK_HALF_MS;

    // register byte offsets
    localparam logic [3:0] CFG_OFS = 4'h0;
    localparam logic [3:0] KEY_OFS = 4'h4;
    localparam logic [3:0] STAT_OFS = 4'h8;
    localparam logic [3:0] LOOP_OFS = 4'hC;

    // configuration register fields
    localparam int CFG_SEL0_LSB = 0;
    localparam int CFG_SEL1_LSB = 4;
    localparam int CFG_TWO_LOOP_BIT = 8;
    localparam int CFG_DIRECT_LSB = 9;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // key register fields (write-one pulses)
    localparam int KEY_MAN_LSB = 0;
    localparam int KEY_SP_LSB = 2;
    localparam int KEY_RUN_BIT = 4;

    // status register fields
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_HOLD_BIT = 1;
    localparam int STAT_CONTACT_LSB = 2;
    localparam int STAT_SEL0_LSB = 8;
    localparam int STAT_SEL1_LSB = 12;

    // loop register: one byte per loop
    localparam int LOOP_MAN_BIT = 0;
    localparam int LOOP_SP_LSB = 1;
    localparam int LOOP_DIRECT_BIT = 3;
    localparam int LOOP_TUNE_BIT = 4;
    localparam int LOOP_PV_LSB = 5;
    localparam int LOOP_STRIDE = 8;

    // per-input selection codes
    typedef enum logic [3:0] {
        SEL_NONE,
        SEL_FORCE_MANUAL,
        SEL_LOCAL_SETPOINT_ONE,
        SEL_LOCAL_SETPOINT_TWO,
        SEL_LOCAL_SETPOINT_THREE,
        SEL_DIRECT_ACTION,
        SEL_PROGRAM_SUSPEND,
        SEL_SECOND_TUNING_SET,
        SEL_PV_FROM_INPUT_TWO,
        SEL_PV_FROM_INPUT_THREE,
        SEL_PROGRAM_RESTART,
        SEL_TOTALIZER_CLEAR
    } cias_sel_t;

    typedef enum logic [1:0] {
        SP_LOCAL1,
        SP_LOCAL2,
        SP_LOCAL3,
        SP_REMOTE
    } cias_sp_t;

    typedef enum logic [1:0] {
        PV_INPUT1,
        PV_INPUT2,
        PV_INPUT3
    } cias_pv_t;

endpackage

// *** cias_debounce.sv ***
// two-flop synchroniser and debouncer for one dry contact
// assumes the contact pin is asynchronous and closed reads high
`timescale 1ns/1ps
module cias_debounce #(
    parameter int unsigned DEBOUNCE_CYCLES = cias_pkg::DEBOUNCE_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic contactPin,
    output logic contactLevel,
    output logic closePulse,
    output logic openPulse
);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic stable;
        logic [31:0] cnt;
        logic rise;
        logic fall;
    } cias_deb_t;

    cias_deb_t stateReg;
    cias_deb_t stateNext;

    // the level must differ from the stable value for the full time before it is taken
    always_comb begin
        stateNext = stateReg;
        stateNext.sync1 = contactPin;
        stateNext.sync2 = stateReg.sync1;
        stateNext.rise = 1'b0;
        stateNext.fall = 1'b0;
        if (stateReg.sync2 == stateReg.stable) begin
            stateNext.cnt = 32'h0000_0000;
        end else if (stateReg.cnt >= 32'(DEBOUNCE_CYCLES - 1)) begin
            stateNext.cnt = 32'h0000_0000;
            stateNext.stable = stateReg.sync2;
            stateNext.rise = stateReg.sync2;
            stateNext.fall = ~stateReg.sync2;
        end else begin
            stateNext.cnt = stateReg.cnt + 32'h0000_0001;
        end
    end

    // state register
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stateReg <= '0;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign contactLevel = stateReg.stable;
    assign closePulse = stateReg.rise;
    assign openPulse = stateReg.fall;

endmodule

// *** cias_blink_div.sv ***
// slow divider giving the blink phase for indicators
// assumes the system clock; the enable pulse is one cycle wide
`timescale 1ns/1ps
module cias_blink_div #(
    parameter int unsigned HALF_CYCLES = cias_pkg::BLINK_HALF_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    output logic blinkPhase
);

    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
        logic phase;
    } cias_blk_t;

    cias_blk_t stateReg;
    cias_blk_t stateNext;

    // tick is a one-cycle enable; the phase flips on it
    always_comb begin
        stateNext = stateReg;
        stateNext.tick = (stateReg.cnt >= 32'(HALF_CYCLES - 1));
        stateNext.cnt = stateNext.tick ? 32'h0000_0000 : stateReg.cnt + 32'h0000_0001;
        if (stateReg.tick) begin
            stateNext.phase = ~stateReg.phase;
        end
    end

    // state register
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stateReg <= '0;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign blinkPhase = stateReg.phase;

endmodule

// *** cias_contact_selector.sv ***
// contact input action selector: two contacts steer loop modes
// assumes an Avalon-MM master on the same clock and raw contact pins
//
// Overview of operation
// - closure of clear input clears totalizer
// - two-loop: input one loop one, two two
// - opening restores state held before closure
// - none selection: no action, indicator off
// - force manual; key press keeps manual
// - setpoint one forced; select key keeps it
// - setpoints two, three behave like one
// - direct action while contact closed
// - hold suspends program; resume if started
// - tuning set two used and shown
// - pv equals input two, indicator blinks
// - restart program, keep run or hold
// - annunciator shows each contact state
// - blink manual, remote, hold indicators
`timescale 1ns/1ps
module cias_contact_selector #(
    parameter int unsigned DEBOUNCE_CYCLES = cias_pkg::DEBOUNCE_CYCLES,
    parameter int unsigned BLINK_HALF_CYCLES = cias_pkg::BLINK_HALF_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [1:0] contactIn,
    output logic [1:0] loopManual,
    output logic [1:0] loopOneSetpoint,
    output logic [1:0] loopTwoSetpoint,
    output logic [1:0] controlDirect,
    output logic [1:0] tuningSetTwo,
    output logic [1:0] loopOnePvSource,
    output logic [1:0] loopTwoPvSource,
    output logic programRun,
    output logic programHold,
    output logic programRestart,
    output logic totalizerClear,
    output logic [1:0] contactInd,
    output logic [1:0] manualInd,
    output logic [1:0] remoteSetpointInd,
    output logic holdInd,
    output logic [1:0] pvInputTwoInd,
    output logic [1:0] pvInputThreeInd
);

    // per-loop mode state with what to restore on opening
    typedef struct packed {
        logic manual;
        logic manForced;
        logic manKeep;
        logic manSaved;
        cias_pkg::cias_sp_t spSel;
        logic spForced;
        logic spKeep;
        cias_pkg::cias_sp_t spSaved;
        logic direct;
        logic tune2;
        cias_pkg::cias_pv_t pvSrc;
    } cias_loop_t;

    typedef struct packed {
        logic ackReg;
        logic [31:0] rdReg;
        cias_pkg::cias_sel_t sel0;
        cias_pkg::cias_sel_t sel1;
        logic twoLoop;
        logic [1:0] directBase;
        cias_loop_t [1:0] lp;
        logic progRun;
        logic holdActive;
        logic holdSaved;
        logic restart;
        logic totClr;
        logic [1:0] indContact;
        logic [1:0] indMan;
        logic [1:0] indRsp;
        logic indHold;
        logic [1:0] indPv2;
        logic [1:0] indPv3;
    } cias_state_t;

    cias_state_t stateReg;
    cias_state_t stateNext;

    logic [1:0] dLevel;
    logic [1:0] dClose;
    logic [1:0] dOpen;
    logic blinkPhase;

    // target loop of an input: both act on loop one unless two-loop is set
    function automatic int loopOf(input int idx, input logic twoLoop);
        loopOf = twoLoop ? idx : 0;
    endfunction

    // merge write data into a register under byte enables
    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        mergeBytes = res;
    endfunction

    // contacts are asynchronous pins, so each passes a synchroniser first
    for (genvar g = 0; g < 2; g++) begin : gDeb
        cias_debounce #(
            .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
        ) uDeb (
            .clock(clock),
            .sys_rst(sys_rst),
            .contactPin(contactIn[g]),
            .contactLevel(dLevel[g]),
            .closePulse(dClose[g]),
            .openPulse(dOpen[g])
        );
    end

    // blink phase shared by all blinking indicators
    cias_blink_div #(
        .HALF_CYCLES(BLINK_HALF_CYCLES)
    ) uBlink (
        .clock(clock),
        .sys_rst(sys_rst),
        .blinkPhase(blinkPhase)
    );

    // bus access is taken on the second cycle so read data comes from a flop
    logic busReq;
    logic busTake;
    logic [31:0] cfgWord;
    logic [31:0] statWord;
    logic [31:0] loopWord;
    assign busReq = read | write;
    assign busTake = busReq & stateReg.ackReg;
    assign waitrequest = busReq & ~stateReg.ackReg;

    // readable views of configuration and state
    always_comb begin
        cfgWord = 32'h0000_0000;
        cfgWord[cias_pkg::CFG_SEL0_LSB +: 4] = stateReg.sel0;
        cfgWord[cias_pkg::CFG_SEL1_LSB +: 4] = stateReg.sel1;
        cfgWord[cias_pkg::CFG_TWO_LOOP_BIT] = stateReg.twoLoop;
        cfgWord[cias_pkg::CFG_DIRECT_LSB +: 2] = stateReg.directBase;
        statWord = 32'h0000_0000;
        statWord[cias_pkg::STAT_RUN_BIT] = stateReg.progRun;
        statWord[cias_pkg::STAT_HOLD_BIT] = stateReg.holdActive;
        statWord[cias_pkg::STAT_CONTACT_LSB +: 2] = dLevel;
        statWord[cias_pkg::STAT_SEL0_LSB +: 4] = stateReg.sel0;
        statWord[cias_pkg::STAT_SEL1_LSB +: 4] = stateReg.sel1;
        loopWord = 32'h0000_0000;
        for (int l = 0; l < 2; l++) begin
            loopWord[l*cias_pkg::LOOP_STRIDE + cias_pkg::LOOP_MAN_BIT] = stateReg.lp[l].manual;
            loopWord[l*cias_pkg::LOOP_STRIDE + cias_pkg::LOOP_SP_LSB +: 2] = stateReg.lp[l].spSel;
            loopWord[l*cias_pkg::LOOP_STRIDE + cias_pkg::LOOP_DIRECT_BIT] = stateReg.lp[l].direct;
            loopWord[l*cias_pkg::LOOP_STRIDE + cias_pkg::LOOP_TUNE_BIT] = stateReg.lp[l].tune2;
            loopWord[l*cias_pkg::LOOP_STRIDE + cias_pkg::LOOP_PV_LSB +: 2] = stateReg.lp[l].pvSrc;
        end
    end

    // next-state logic: bus, keys, then contact edges and levels
    always_comb begin
        logic [31:0] cfgNew;
        cias_pkg::cias_sel_t sel;
        int t;
        cfgNew = cfgWord;
        sel = cias_pkg::SEL_NONE;
        t = 0;
        stateNext = stateReg;
        stateNext.ackReg = busReq & ~stateReg.ackReg;
        stateNext.restart = 1'b0;
        stateNext.totClr = 1'b0;

        // register reads; unmapped offsets read as zero
        if (read & ~stateReg.ackReg) begin
            case (address)
                cias_pkg::CFG_OFS: stateNext.rdReg = cfgWord;
                cias_pkg::STAT_OFS: stateNext.rdReg = statWord;
                cias_pkg::LOOP_OFS: stateNext.rdReg = loopWord;
                default: stateNext.rdReg = 32'h0000_0000;
            endcase
        end

        // configuration write
        if (write & busTake && address == cias_pkg::CFG_OFS) begin
            cfgNew = mergeBytes(cfgWord, writedata, byteenable);
            stateNext.sel0 = cias_pkg::cias_sel_t'(cfgNew[cias_pkg::CFG_SEL0_LSB +: 4]);
            stateNext.sel1 = cias_pkg::cias_sel_t'(cfgNew[cias_pkg::CFG_SEL1_LSB +: 4]);
            stateNext.twoLoop = cfgNew[cias_pkg::CFG_TWO_LOOP_BIT];
            stateNext.directBase = cfgNew[cias_pkg::CFG_DIRECT_LSB +: 2];
        end

        // front-panel keys; while a contact holds the loop they only set the keep flag
        if (write & busTake && address == cias_pkg::KEY_OFS && byteenable[0]) begin
            for (int l = 0; l < 2; l++) begin
                if (writedata[cias_pkg::KEY_MAN_LSB + l]) begin
                    if (stateReg.lp[l].manForced) begin
                        stateNext.lp[l].manKeep = 1'b1;
                    end else begin
                        stateNext.lp[l].manual = ~stateReg.lp[l].manual;
                    end
                end
                if (writedata[cias_pkg::KEY_SP_LSB + l]) begin
                    if (stateReg.lp[l].spForced) begin
                        stateNext.lp[l].spKeep = 1'b1;
                    end else begin
                        stateNext.lp[l].spSel = cias_pkg::cias_sp_t'(stateReg.lp[l].spSel + 2'h1);
                    end
                end
            end
            if (writedata[cias_pkg::KEY_RUN_BIT] && !stateReg.holdActive) begin
                stateNext.progRun = ~stateReg.progRun;
            end
        end

        // level-type selections are rebuilt every cycle, so opening restores them
        for (int l = 0; l < 2; l++) begin
            stateNext.lp[l].direct = stateReg.directBase[l];
            stateNext.lp[l].tune2 = 1'b0;
            stateNext.lp[l].pvSrc = cias_pkg::PV_INPUT1;
        end

        // act on each input; input one is applied last so it wins a shared loop
        for (int i = 1; i >= 0; i--) begin
            sel = (i == 0) ? stateReg.sel0 : stateReg.sel1;
            t = loopOf(i, stateReg.twoLoop);
            case (sel)
                cias_pkg::SEL_FORCE_MANUAL: begin
                    if (dClose[i]) begin
                        stateNext.lp[t].manSaved = stateNext.lp[t].manual;
                        stateNext.lp[t].manual = 1'b1;
                        stateNext.lp[t].manForced = 1'b1;
                        stateNext.lp[t].manKeep = 1'b0;
                    end else if (dOpen[i]) begin
                        if (!stateNext.lp[t].manKeep) begin
                            stateNext.lp[t].manual = stateReg.lp[t].manSaved;
                        end
                        stateNext.lp[t].manForced = 1'b0;
                    end
                end
                cias_pkg::SEL_LOCAL_SETPOINT_ONE, cias_pkg::SEL_LOCAL_SETPOINT_TWO,
                cias_pkg::SEL_LOCAL_SETPOINT_THREE: begin
                    if (dClose[i]) begin
                        stateNext.lp[t].spSaved = stateNext.lp[t].spSel;
                        stateNext.lp[t].spForced = 1'b1;
                        stateNext.lp[t].spKeep = 1'b0;
                        if (sel == cias_pkg::SEL_LOCAL_SETPOINT_ONE) begin
                            stateNext.lp[t].spSel = cias_pkg::SP_LOCAL1;
                        end else if (sel == cias_pkg::SEL_LOCAL_SETPOINT_TWO) begin
                            stateNext.lp[t].spSel = cias_pkg::SP_LOCAL2;
                        end else begin
                            stateNext.lp[t].spSel = cias_pkg::SP_LOCAL3;
                        end
                    end else if (dOpen[i]) begin
                        if (!stateNext.lp[t].spKeep) begin
                            stateNext.lp[t].spSel = stateReg.lp[t].spSaved;
                        end
                        stateNext.lp[t].spForced = 1'b0;
                    end
                end
                cias_pkg::SEL_DIRECT_ACTION: begin
                    if (dLevel[i]) begin
                        stateNext.lp[t].direct = 1'b1;
                    end
                end
                cias_pkg::SEL_PROGRAM_SUSPEND: begin
                    // the program is shared, so this acts whichever loop is targeted
                    if (dClose[i]) begin
                        stateNext.holdSaved = stateNext.progRun;
                        stateNext.progRun = 1'b0;
                        stateNext.holdActive = 1'b1;
                    end else if (dOpen[i]) begin
                        stateNext.progRun = stateReg.holdSaved;
                        stateNext.holdActive = 1'b0;
                    end
                end
                cias_pkg::SEL_SECOND_TUNING_SET: begin
                    if (dLevel[i]) begin
                        stateNext.lp[t].tune2 = 1'b1;
                    end
                end
                cias_pkg::SEL_PV_FROM_INPUT_TWO: begin
                    if (dLevel[i]) begin
                        stateNext.lp[t].pvSrc = cias_pkg::PV_INPUT2;
                    end
                end
                cias_pkg::SEL_PV_FROM_INPUT_THREE: begin
                    if (dLevel[i]) begin
                        stateNext.lp[t].pvSrc = cias_pkg::PV_INPUT3;
                    end
                end
                cias_pkg::SEL_PROGRAM_RESTART: begin
                    // run or hold is left untouched; opening does nothing
                    if (dClose[i]) begin
                        stateNext.restart = 1'b1;
                    end
                end
                cias_pkg::SEL_TOTALIZER_CLEAR: begin
                    if (dClose[i]) begin
                        stateNext.totClr = 1'b1;
                    end
                end
                default: begin
                    // no selection: contact changes are ignored
                end
            endcase
        end

        // indicators; registered so they never glitch on the panel
        for (int i = 0; i < 2; i++) begin
            sel = (i == 0) ? stateReg.sel0 : stateReg.sel1;
            stateNext.indContact[i] = dLevel[i] & (sel != cias_pkg::SEL_NONE);
        end
        for (int l = 0; l < 2; l++) begin
            stateNext.indMan[l] = stateReg.lp[l].manForced ? blinkPhase : stateReg.lp[l].manual;
            stateNext.indRsp[l] = (stateReg.lp[l].spForced && stateReg.lp[l].spSel != cias_pkg::SP_LOCAL1)
                ? blinkPhase : (stateReg.lp[l].spSel == cias_pkg::SP_REMOTE);
            stateNext.indPv2[l] = (stateReg.lp[l].pvSrc == cias_pkg::PV_INPUT2) & blinkPhase;
            stateNext.indPv3[l] = (stateReg.lp[l].pvSrc == cias_pkg::PV_INPUT3) & blinkPhase;
        end
        stateNext.indHold = stateReg.holdActive ? blinkPhase : 1'b0;
    end

    // state register
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stateReg <= '0;
        end else begin
            stateReg <= stateNext;
        end
    end

    // outputs straight from the state flops
    assign readdata = stateReg.rdReg;
    assign loopManual = {stateReg.lp[1].manual, stateReg.lp[0].manual};
    assign loopOneSetpoint = stateReg.lp[0].spSel;
    assign loopTwoSetpoint = stateReg.lp[1].spSel;
    assign controlDirect = {stateReg.lp[1].direct, stateReg.lp[0].direct};
    assign tuningSetTwo = {stateReg.lp[1].tune2, stateReg.lp[0].tune2};
    assign loopOnePvSource = stateReg.lp[0].pvSrc;
    assign loopTwoPvSource = stateReg.lp[1].pvSrc;
    assign programRun = stateReg.progRun;
    assign programHold = ~stateReg.progRun;
    assign programRestart = stateReg.restart;
    assign totalizerClear = stateReg.totClr;
    assign contactInd = stateReg.indContact;
    assign manualInd = stateReg.indMan;
    assign remoteSetpointInd = stateReg.indRsp;
    assign holdInd = stateReg.indHold;
    assign pvInputTwoInd = stateReg.indPv2;
    assign pvInputThreeInd = stateReg.indPv3;

endmodule

// *** cias_contact_checker.sv ***
// assertions on the contact selector top ports
// assumes binding onto cias_contact_selector, one clock domain
`timescale 1ns/1ps
module cias_contact_checker (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic read,
    input wire logic waitrequest,
    input wire logic [1:0] contactIn,
    input wire logic [1:0] contactInd,
    input wire logic [1:0] loopOnePvSource,
    input wire logic [1:0] pvInputTwoInd,
    input wire logic programRun,
    input wire logic programHold,
    input wire logic programRestart,
    input wire logic totalizerClear,
    input wire logic holdInd
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // a read waits exactly one cycle before its answer
    sequence s_one_wait;
        waitrequest ##1 !waitrequest;
    endsequence
    bus_wait_a: assert property ($rose(read) |-> s_one_wait)
        else $error("read answer timing wrong");
    // the annunciator only rises if the pin was closed three cycles earlier
    ann_follow_a: assert property ($rose(contactInd[0]) |-> $past(contactIn[0], 3))
        else $error("indicator rose without closure");
    restart_pulse_a: assert property (programRestart |=> !programRestart)
        else $error("restart pulse too long");
    restart_cause_a: assert property (programRestart |-> $past(contactIn[0], 3) || $past(contactIn[1], 3))
        else $error("restart without closure");
    clear_pulse_a: assert property (totalizerClear |=> !totalizerClear)
        else $error("clear pulse too long");
    clear_cause_a: assert property (totalizerClear |-> $past(contactIn[0], 3) || $past(contactIn[1], 3))
        else $error("clear without closure");
    hold_state_a: assert property (programHold == !programRun)
        else $error("hold and run disagree");
    // indicators lag the mode by one edge, hence the look back
    hold_blink_a: assert property (holdInd |-> !$past(programRun))
        else $error("hold indicator while running");
    pv_blink_a: assert property (pvInputTwoInd[0] |-> $past(loopOnePvSource) == 2'h1)
        else $error("pv indicator without source two");
endmodule

bind cias_contact_selector cias_contact_checker chk (.clock, .sys_rst, .read, .waitrequest, .contactIn,
    .contactInd, .loopOnePvSource, .pvInputTwoInd, .programRun, .programHold, .programRestart,
    .totalizerClear, .holdInd);

// *** cias_contact_model.sv ***
// pair of dry contacts closed and opened on command
// assumes the bench changes commands just after clock edges
`timescale 1ns/1ps
module cias_contact_model (
    input wire logic clock,
    input wire logic [1:0] closeCmd,
    input wire logic [1:0] glitchCmd,
    output logic [1:0] contactIn
);
    // a glitch flips a contact for one cycle, like a short bounce
    initial contactIn = 2'h0;
    always @(posedge clock) begin
        contactIn <= closeCmd ^ glitchCmd;
    end
endmodule

// *** cias_contact_selector_test.sv ***
// self-checking bench for the contact selector
// assumes short debounce and blink counts for a quick run
`timescale 1ns/1ps
module cias_contact_selector_test;
    logic clock = 0, sys_rst = 1, read = 0, write = 0;
    logic [3:0] address = 4'h0, byteenable = 4'hF;
    logic [31:0] writedata = 32'h0, readdata, rd;
    logic [1:0] closeCmd = 2'h0, glitchCmd = 2'h0, contactIn, loopManual, loopOneSetpoint;
    logic [1:0] controlDirect, tuningSetTwo, loopOnePvSource, contactInd;
    logic waitrequest, programRun, programRestart, totalizerClear;
    int bad_count = 0, checked = 0, pulses = 0, n;
    // selection code beside the loop one mode it should force
    logic [11:0] rows [9] = '{{cias_pkg::SEL_NONE, 8'h00}, {cias_pkg::SEL_FORCE_MANUAL, 8'h01},
        {cias_pkg::SEL_LOCAL_SETPOINT_ONE, 8'h00}, {cias_pkg::SEL_LOCAL_SETPOINT_TWO, 8'h02},
        {cias_pkg::SEL_LOCAL_SETPOINT_THREE, 8'h04}, {cias_pkg::SEL_DIRECT_ACTION, 8'h08},
        {cias_pkg::SEL_SECOND_TUNING_SET, 8'h10}, {cias_pkg::SEL_PV_FROM_INPUT_TWO, 8'h20},
        {cias_pkg::SEL_PV_FROM_INPUT_THREE, 8'h40}};
    wire [7:0] mode = {1'b0, loopOnePvSource, tuningSetTwo[0], controlDirect[0], loopOneSetpoint, loopManual[0]};

    cias_contact_model contacts (.clock, .closeCmd, .glitchCmd, .contactIn);
    cias_contact_selector #(.DEBOUNCE_CYCLES(4), .BLINK_HALF_CYCLES(8)) uut (.clock, .sys_rst, .address,
        .read, .write, .byteenable, .writedata, .readdata, .waitrequest, .contactIn, .loopManual,
        .loopOneSetpoint, .loopTwoSetpoint(), .controlDirect, .tuningSetTwo, .loopOnePvSource,
        .loopTwoPvSource(), .programRun, .programHold(), .programRestart, .totalizerClear, .contactInd,
        .manualInd(), .remoteSetpointInd(), .holdInd(), .pvInputTwoInd(), .pvInputThreeInd());

    initial begin
        forever #2.5 clock = ~clock;
    end
    // pulse counter: both pulses are one cycle, so counting edges is exact
    always @(posedge clock) begin
        pulses <= pulses + int'(programRestart) + int'(totalizerClear);
    end

    task automatic wrap_up;
        if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // hold the request until waitrequest is sampled low at a rising edge, then release
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        @(posedge clock);
        while (waitrequest !== 1'b0) @(posedge clock);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    // long enough for sync, debounce and the indicator lag
    task automatic sw(input logic [1:0] c);
        @(posedge clock);
        closeCmd <= c;
        repeat (14) @(posedge clock);
        @(negedge clock);
    endtask

    initial begin
        #50000;
        bad_count++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        bus(1'b0, 4'h2, 32'h0);
        cmp(rd[7:0], 8'h00);
        foreach (rows[i]) begin
            bus(1'b1, cias_pkg::CFG_OFS, {28'h0, rows[i][11:8]});
            sw(2'h1);
            cmp(mode, rows[i][7:0]);
            cmp({7'h0, contactInd[0]}, {7'h0, i != 0});
            sw(2'h0);
            cmp(mode, 8'h00);
        end
        // a single-cycle bounce must not fire a clear pulse
        bus(1'b1, cias_pkg::CFG_OFS, {28'h0, cias_pkg::SEL_TOTALIZER_CLEAR});
        n = pulses;
        @(posedge clock);
        glitchCmd <= 2'h1;
        @(posedge clock);
        glitchCmd <= 2'h0;
        sw(2'h0);
        cmp(8'(pulses - n), 8'h00);
        // two loops: input two drives loop two only
        bus(1'b1, cias_pkg::CFG_OFS, 32'h0000_0150);
        sw(2'h2);
        cmp({6'h0, controlDirect}, 8'h02);
        sw(2'h0);
        // start the program, then suspend and resume it
        bus(1'b1, cias_pkg::KEY_OFS, 32'h0000_0010);
        bus(1'b1, cias_pkg::CFG_OFS, {28'h0, cias_pkg::SEL_PROGRAM_SUSPEND});
        sw(2'h1);
        cmp({7'h0, programRun}, 8'h00);
        bus(1'b0, cias_pkg::STAT_OFS, 32'h0);
        cmp({4'h0, rd[3:0]}, 8'h06);
        sw(2'h0);
        cmp({7'h0, programRun}, 8'h01);
        // restart and clear fire once per closure, never on opening
        for (int k = 10; k < 12; k++) begin
            bus(1'b1, cias_pkg::CFG_OFS, k);
            n = pulses;
            sw(2'h1);
            sw(2'h0);
            cmp(8'(pulses - n), 8'h01);
            cmp({7'h0, programRun}, 8'h01);
        end
        // manual key while forced keeps manual after opening
        bus(1'b1, cias_pkg::CFG_OFS, {28'h0, cias_pkg::SEL_FORCE_MANUAL});
        sw(2'h1);
        bus(1'b1, cias_pkg::KEY_OFS, 32'h0000_0001);
        sw(2'h0);
        cmp({7'h0, loopManual[0]}, 8'h01);
        // setpoint one overrides local two and gives it back on opening
        bus(1'b1, cias_pkg::KEY_OFS, 32'h0000_0004);
        bus(1'b1, cias_pkg::CFG_OFS, {28'h0, cias_pkg::SEL_LOCAL_SETPOINT_ONE});
        sw(2'h1);
        cmp({6'h0, loopOneSetpoint}, 8'h00);
        sw(2'h0);
        cmp({6'h0, loopOneSetpoint}, 8'h01);
        // a mid-run reset drops the kept manual mode and the running program
        @(posedge clock);
        sys_rst <= 1'b1;
        @(posedge clock);
        sys_rst <= 1'b0;
        @(negedge clock);
        cmp(mode, 8'h00);
        cmp({7'h0, programRun}, 8'h00);
        wrap_up();
    end
endmodule
